// ### verilog/gdft_pkg.sv
package gdft_pkg;

  // ----------------------------------------
  // Clock and widths
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 100;
  localparam int MEAS_W = 8;
  localparam int CNT_W = 16;

  // ----------------------------------------
  // Times
  // ----------------------------------------
  localparam int STATUS_DELAY_NS = 500;
  localparam int BLOCK_TIME_NS = 20_000;
  localparam int DC_LINK_CARRIER_HZ = 5_000;
  localparam int TEMP_CARRIER_HZ = 4_000;
  localparam int DC_LINK_FILTER_NS = 2_000;
  localparam int TEMP_FILTER_NS = 5_000;
  localparam int DC_LINK_DELAY_NS = 10_000;
  localparam int TEMP_DELAY_NS = 20_000;

  function automatic int cyc_ceil(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_ceil

  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam int REPORT_CYC = cyc_ceil(STATUS_DELAY_NS);
  localparam int BLOCK_CYC = cyc_ceil(BLOCK_TIME_NS);
  localparam int DLK_PERIOD_CYC = CLK_HZ / DC_LINK_CARRIER_HZ;
  localparam int TPM_PERIOD_CYC = CLK_HZ / TEMP_CARRIER_HZ;
  localparam int DLK_FILT_CYC = cyc_ceil(DC_LINK_FILTER_NS);
  localparam int TPM_FILT_CYC = cyc_ceil(TEMP_FILTER_NS);
  localparam int DLK_DLY_CYC = cyc_ceil(DC_LINK_DELAY_NS);
  localparam int TPM_DLY_CYC = cyc_ceil(TEMP_DELAY_NS);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    CH_RUN, CH_REPORT, CH_BLOCK, CH_WAIT
  } gdft_chan_state_t;

  typedef struct packed {
    logic cmd_rise;
    logic cmd_fall;
    logic short_det;
    logic sec_undervolt;
    logic pri_undervolt;
  } gdft_chan_in_t;

  typedef struct packed {
    gdft_chan_state_t state;
    logic [CNT_W-1:0] cnt;
    logic gate_on;
    logic status_n;
  } gdft_chan_st_t;

  typedef struct packed {
    logic [MEAS_W-1:0] cand;
    logic [MEAS_W-1:0] acc;
    logic [CNT_W-1:0] stab;
    logic [CNT_W-1:0] dly;
    logic pend;
    logic [CNT_W-1:0] next_duty;
    logic [CNT_W-1:0] duty;
    logic [CNT_W-1:0] phase;
    logic pwm;
  } gdft_pwm_st_t;

  typedef struct packed {
    logic hs_prev;
    logic ls_prev;
    logic fault_led;
    logic power_led;
    logic dc_link_pwm_out;
    logic temperature_pwm_out;
  } gdft_top_st_t;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam gdft_chan_st_t CHAN_RST = '{
    state: CH_RUN, cnt: '0, gate_on: 1'b0, status_n: 1'b1};
  localparam gdft_pwm_st_t PWM_RST = '0;
  localparam gdft_top_st_t TOP_RST = '{
    hs_prev: 1'b0, ls_prev: 1'b0, fault_led: 1'b0,
    power_led: 1'b1, dc_link_pwm_out: 1'b0, temperature_pwm_out: 1'b0};

endpackage : gdft_pkg

// ### verilog/gdft_chan.sv
`timescale 1ns/10ps
module gdft_chan
  import gdft_pkg::*;
#(
  parameter int REPORT_CYCLES = REPORT_CYC,
  parameter int BLOCK_CYCLES = BLOCK_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Channel events
  input wire gdft_chan_in_t i_ev,
  // Channel outputs
  output logic o_gate_on,
  output logic o_status_n,
  output logic o_idle
);

  localparam logic [CNT_W-1:0] REP_LD = CNT_W'(REPORT_CYCLES - 1);
  localparam logic [CNT_W-1:0] BLK_LD = CNT_W'(BLOCK_CYCLES - 1);

  gdft_chan_st_t st_q;
  gdft_chan_st_t st_d;

  // ----------------------------------------
  // Fault sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q.state)
      CH_RUN: begin
        // (RULE17) edge commands
        if (i_ev.cmd_rise) begin
          st_d.gate_on = 1'b1;
        end else if (i_ev.cmd_fall) begin
          st_d.gate_on = 1'b0;
        end
      end
      CH_REPORT: begin
        // (RULE2) report delay
        if (st_q.cnt == '0) begin
          st_d.state = CH_BLOCK;
          st_d.cnt = BLK_LD;
        end else begin
          st_d.cnt = st_q.cnt - 1'b1;
        end
      end
      CH_BLOCK: begin
        // (RULE3) auto release
        if (st_q.cnt == '0) begin
          st_d.state = CH_WAIT;
        end else begin
          st_d.cnt = st_q.cnt - 1'b1;
        end
      end
      CH_WAIT: begin
        // (RULE4) fresh turn-on
        if (i_ev.cmd_rise) begin
          st_d.state = CH_RUN;
          st_d.gate_on = 1'b1;
        end
      end
      default: st_d = CHAN_RST;
    endcase
    // (RULE1) immediate switch-off
    if (i_ev.short_det &&
        (st_q.state == CH_RUN || st_q.state == CH_WAIT)) begin
      st_d.state = CH_REPORT;
      st_d.cnt = REP_LD;
      st_d.gate_on = 1'b0;
    end
    if (i_ev.sec_undervolt && st_q.state != CH_BLOCK &&
        st_q.state != CH_REPORT) begin
      st_d.state = CH_BLOCK;
      st_d.cnt = BLK_LD;
      st_d.gate_on = 1'b0;
    end
    // (RULE19) primary undervoltage hold
    if (i_ev.pri_undervolt) begin
      st_d.state = CH_BLOCK;
      st_d.cnt = BLK_LD;
      st_d.gate_on = 1'b0;
    end
    // (RULE18) status low while blocking
    st_d.status_n = (st_d.state != CH_BLOCK);
    // (RULE20) no gate while blocked
    if (st_d.state == CH_BLOCK || st_d.state == CH_REPORT) begin
      st_d.gate_on = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= CHAN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_gate_on = st_q.gate_on;
  assign o_status_n = st_q.status_n;
  assign o_idle = (st_q.state == CH_RUN);

endmodule : gdft_chan

// ### verilog/gdft_pwm.sv
`timescale 1ns/10ps
module gdft_pwm
  import gdft_pkg::*;
#(
  parameter int PERIOD = DLK_PERIOD_CYC,
  parameter int FILT = DLK_FILT_CYC,
  parameter int DLY = DLK_DLY_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Measurement in, coded out
  input wire logic [MEAS_W-1:0] i_meas,
  output logic o_pwm
);

  localparam logic [CNT_W-1:0] PER_LAST = CNT_W'(PERIOD - 1);
  localparam logic [CNT_W-1:0] FILT_LAST = CNT_W'(FILT - 1);
  localparam logic [CNT_W-1:0] DLY_LD = CNT_W'(DLY - 1);
  localparam int PW = CNT_W + MEAS_W;

  function automatic logic [CNT_W-1:0] scale(
    input logic [MEAS_W-1:0] v);
    logic [PW-1:0] p;
    p = PW'(v) * PW'(PERIOD);
    return p[PW-1:MEAS_W];
  endfunction : scale

  gdft_pwm_st_t st_q;
  gdft_pwm_st_t st_d;

  // ----------------------------------------
  // Filter, delay, carrier
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    // (RULE7) transfer delay
    if (st_q.pend) begin
      if (st_q.dly == '0) begin
        st_d.next_duty = scale(st_q.acc);
        st_d.pend = 1'b0;
      end else begin
        st_d.dly = st_q.dly - 1'b1;
      end
    end
    // (RULE7) noise filter
    if (i_meas != st_q.cand) begin
      st_d.cand = i_meas;
      st_d.stab = '0;
    end else if (st_q.stab != FILT_LAST) begin
      st_d.stab = st_q.stab + 1'b1;
    end else if (st_q.cand != st_q.acc) begin
      st_d.acc = st_q.cand;
      st_d.dly = DLY_LD;
      st_d.pend = 1'b1;
    end
    // (RULE6) fixed carrier
    if (st_q.phase == PER_LAST) begin
      st_d.phase = '0;
      st_d.duty = st_q.next_duty;
    end else begin
      st_d.phase = st_q.phase + 1'b1;
    end
    st_d.pwm = (st_d.phase < st_d.duty);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= PWM_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_pwm = st_q.pwm;

endmodule : gdft_pwm

// ### verilog/gdft_top.sv
`timescale 1ns/10ps
// Contract
// (RULE1) Detected short circuit switches the semiconductor off at once.
// (RULE2) Status output goes to fault level after the report delay.
// (RULE3) Fault status releases itself after the blocking time.
// (RULE4) After a fault, only a fresh turn-on command restarts switching.
// (RULE5) DC-link value comes from the first driver on the cable.
// (RULE6) DC-link output is PWM on a fixed carrier.
// (RULE7) DC-link read-out is filtered and delayed by fixed times.
// (RULE8) Temperature output reports the hottest connected driver only.
// (RULE9) Temperature output is fixed-carrier PWM, filtered and delayed.
// (RULE10) Missing thermistor holds temperature output statically high.
// (RULE11) Internal communication error holds both outputs low.
// (RULE12) Self-test error: DC-link output high, temperature output low.
// (RULE13) Fault light latches on short or undervoltage anywhere.
// (RULE14) Fault light clears on turn-on edge once all faults gone.
// (RULE15) Supply light is on whenever the unit is powered.
// (RULE16) Missing driver-to-driver cable is not detected.
// (RULE17) Command inputs are active high and edge-triggered.
// (RULE18) Status rests high; on fault low for the blocking time.
// (RULE19) Primary undervoltage pulls both statuses low, gates off.
// (RULE20) No gate commands while a status is blocking.
// (RULE21) Carrier, filter, delay, report and blocking times are parameters.
module gdft_top
  import gdft_pkg::*;
#(
  parameter int N_DRIVERS = 4,
  // (RULE21) timing parameters
  parameter int REPORT_CYCLES = REPORT_CYC,
  parameter int BLOCK_CYCLES = BLOCK_CYC,
  parameter int DLK_PERIOD = DLK_PERIOD_CYC,
  parameter int DLK_FILT = DLK_FILT_CYC,
  parameter int DLK_DLY = DLK_DLY_CYC,
  parameter int TPM_PERIOD = TPM_PERIOD_CYC,
  parameter int TPM_FILT = TPM_FILT_CYC,
  parameter int TPM_DLY = TPM_DLY_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Commands from system controller
  input wire logic i_high_side_command_in,
  input wire logic i_low_side_command_in,
  // Fault detectors
  input wire logic i_high_side_short_det,
  input wire logic i_low_side_short_det,
  input wire logic i_high_side_undervolt,
  input wire logic i_low_side_undervolt,
  input wire logic i_primary_undervolt,
  // Measurements and driver state
  input wire logic [MEAS_W-1:0] i_dc_link_meas,
  input wire logic [N_DRIVERS-1:0][MEAS_W-1:0] i_temp_meas,
  input wire logic [N_DRIVERS-1:0] i_driver_present,
  input wire logic [N_DRIVERS-1:0] i_ntc_present,
  input wire logic i_comm_error,
  input wire logic i_self_test_error,
  // Gate commands
  output logic o_high_side_gate_on,
  output logic o_low_side_gate_on,
  // Status and telemetry
  output logic o_high_side_fault_status_out_n,
  output logic o_low_side_fault_status_out_n,
  output logic o_dc_link_pwm_out,
  output logic o_temperature_pwm_out,
  // Indicators
  output logic o_fault_led,
  output logic o_power_led
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [MEAS_W-1:0] hottest(
    input logic [N_DRIVERS-1:0][MEAS_W-1:0] t,
    input logic [N_DRIVERS-1:0] en);
    logic [MEAS_W-1:0] m;
    m = '0;
    for (int i = 0; i < N_DRIVERS; i++) begin
      if (en[i] && t[i] > m) begin
        m = t[i];
      end
    end
    return m;
  endfunction : hottest

  gdft_top_st_t st_q;
  gdft_top_st_t st_d;
  gdft_chan_in_t hs_ev;
  gdft_chan_in_t ls_ev;
  logic hs_rise;
  logic ls_rise;
  logic hs_idle;
  logic ls_idle;
  logic dlk_pwm;
  logic tpm_pwm;
  logic ntc_missing;
  logic any_fault;
  logic led_clear;
  logic [MEAS_W-1:0] temp_max;

  // ----------------------------------------
  // Command edges
  // ----------------------------------------
  // (RULE17) edge detect
  assign hs_rise = i_high_side_command_in && !st_q.hs_prev;
  assign ls_rise = i_low_side_command_in && !st_q.ls_prev;

  assign hs_ev = '{
    cmd_rise: hs_rise,
    cmd_fall: !i_high_side_command_in && st_q.hs_prev,
    short_det: i_high_side_short_det,
    sec_undervolt: i_high_side_undervolt,
    pri_undervolt: i_primary_undervolt};
  assign ls_ev = '{
    cmd_rise: ls_rise,
    cmd_fall: !i_low_side_command_in && st_q.ls_prev,
    short_det: i_low_side_short_det,
    sec_undervolt: i_low_side_undervolt,
    pri_undervolt: i_primary_undervolt};

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  gdft_chan #(
    .REPORT_CYCLES(REPORT_CYCLES),
    .BLOCK_CYCLES(BLOCK_CYCLES)
  ) u_hs_chan (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_ev(hs_ev),
    .o_gate_on(o_high_side_gate_on),
    .o_status_n(o_high_side_fault_status_out_n),
    .o_idle(hs_idle)
  );

  gdft_chan #(
    .REPORT_CYCLES(REPORT_CYCLES),
    .BLOCK_CYCLES(BLOCK_CYCLES)
  ) u_ls_chan (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_ev(ls_ev),
    .o_gate_on(o_low_side_gate_on),
    .o_status_n(o_low_side_fault_status_out_n),
    .o_idle(ls_idle)
  );

  // ----------------------------------------
  // Telemetry coders
  // ----------------------------------------
  // (RULE5) first driver value only
  // (RULE16) no cable presence check
  gdft_pwm #(
    .PERIOD(DLK_PERIOD),
    .FILT(DLK_FILT),
    .DLY(DLK_DLY)
  ) u_dlk_pwm (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_meas(i_dc_link_meas),
    .o_pwm(dlk_pwm)
  );

  // (RULE8) hottest driver
  assign temp_max = hottest(i_temp_meas, i_driver_present);

  // (RULE9) temperature coder
  gdft_pwm #(
    .PERIOD(TPM_PERIOD),
    .FILT(TPM_FILT),
    .DLY(TPM_DLY)
  ) u_tpm_pwm (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_meas(temp_max),
    .o_pwm(tpm_pwm)
  );

  assign ntc_missing = |(i_driver_present & ~i_ntc_present);

  // ----------------------------------------
  // Indicators and output states
  // ----------------------------------------
  assign any_fault = i_high_side_short_det || i_low_side_short_det ||
                     i_high_side_undervolt || i_low_side_undervolt ||
                     i_primary_undervolt;
  assign led_clear = (hs_rise || ls_rise) && !i_primary_undervolt &&
                     o_high_side_fault_status_out_n &&
                     o_low_side_fault_status_out_n;

  always_comb begin
    st_d = st_q;
    st_d.hs_prev = i_high_side_command_in;
    st_d.ls_prev = i_low_side_command_in;
    // (RULE13) latch fault light
    if (any_fault) begin
      st_d.fault_led = 1'b1;
    // (RULE14) clear on turn-on edge
    end else if (led_clear) begin
      st_d.fault_led = 1'b0;
    end
    // (RULE15) supply light
    st_d.power_led = 1'b1;
    // (RULE11) communication error
    if (i_comm_error) begin
      st_d.dc_link_pwm_out = 1'b0;
      st_d.temperature_pwm_out = 1'b0;
    // (RULE12) self-test error
    end else if (i_self_test_error) begin
      st_d.dc_link_pwm_out = 1'b1;
      st_d.temperature_pwm_out = 1'b0;
    end else begin
      st_d.dc_link_pwm_out = dlk_pwm;
      // (RULE10) no thermistor
      st_d.temperature_pwm_out = ntc_missing ? 1'b1 : tpm_pwm;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= TOP_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_dc_link_pwm_out = st_q.dc_link_pwm_out;
  assign o_temperature_pwm_out = st_q.temperature_pwm_out;
  assign o_fault_led = st_q.fault_led;
  assign o_power_led = st_q.power_led;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  logic [CNT_W-1:0] low_cnt_q;
  logic pri_seen_q;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      low_cnt_q <= '0;
      pri_seen_q <= 1'b0;
    end else begin
      if (o_high_side_fault_status_out_n) begin
        low_cnt_q <= '0;
      end else begin
        low_cnt_q <= low_cnt_q + 1'b1;
      end
      if (i_primary_undervolt) begin
        pri_seen_q <= 1'b1;
      end else if (o_high_side_fault_status_out_n) begin
        pri_seen_q <= 1'b0;
      end
    end
  end

  sequence s_report;
    o_high_side_fault_status_out_n[*5] ##1
      !o_high_side_fault_status_out_n;
  endsequence

  // (RULE1) gate off at once
  a_short_gate_off: // (RULE1)
    assert property (i_high_side_short_det |=> !o_high_side_gate_on)
    else $error("gate stayed on after short");

  // (RULE2) status after delay
  a_report_delay: // (RULE2)
    assert property (@(posedge i_core_clk)
      disable iff (i_srst || i_primary_undervolt)
      hs_idle && i_high_side_short_det |=> s_report)
    else $error("status delay wrong");

  // (RULE3) release bounded
  a_block_bound: // (RULE3)
    assert property (pri_seen_q ||
      low_cnt_q <= CNT_W'(BLOCK_CYCLES))
    else $error("status not released");

  // (RULE18) blocking length
  a_block_length: // (RULE18)
    assert property ($rose(o_high_side_fault_status_out_n) |->
      pri_seen_q || low_cnt_q == CNT_W'(BLOCK_CYCLES))
    else $error("blocking time wrong");

  // (RULE4) fresh command only
  a_fresh_turn_on: // (RULE4)
    assert property ($rose(o_high_side_gate_on) |-> $past(hs_rise))
    else $error("gate on without command edge");

  // (RULE20) no gate while blocked
  a_block_no_gate: // (RULE20)
    assert property (!o_low_side_fault_status_out_n |->
      !o_low_side_gate_on)
    else $error("gate on while blocked");

  // (RULE19) primary undervoltage
  a_primary_off: // (RULE19)
    assert property (i_primary_undervolt |=>
      !o_high_side_fault_status_out_n &&
      !o_low_side_fault_status_out_n &&
      !o_high_side_gate_on && !o_low_side_gate_on)
    else $error("primary undervoltage not handled");

  // (RULE13) fault light set
  a_led_set: // (RULE13)
    assert property (any_fault |=> o_fault_led)
    else $error("fault light not latched");

  // (RULE14) fault light clear
  a_led_clear: // (RULE14)
    assert property ($fell(o_fault_led) |->
      $past(led_clear) && !$past(any_fault))
    else $error("fault light cleared wrongly");

  // (RULE11) communication error
  a_comm_low: // (RULE11)
    assert property (i_comm_error |=>
      !o_dc_link_pwm_out && !o_temperature_pwm_out)
    else $error("comm error outputs wrong");

  // (RULE12) self-test error
  a_self_test: // (RULE12)
    assert property (!i_comm_error && i_self_test_error |=>
      o_dc_link_pwm_out && !o_temperature_pwm_out)
    else $error("self-test outputs wrong");

  // (RULE10) missing thermistor
  a_ntc_high: // (RULE10)
    assert property (!i_comm_error && !i_self_test_error &&
      ntc_missing |=> o_temperature_pwm_out)
    else $error("missing thermistor not shown");

  // (RULE15) supply light
  a_power_on: // (RULE15)
    assert property (##1 o_power_led)
    else $error("supply light off");

  // (RULE6) normal path follows coder
  a_dlk_follow: // (RULE6)
    assert property (!i_comm_error && !i_self_test_error |=>
      o_dc_link_pwm_out == $past(dlk_pwm))
    else $error("dc-link output not the coder");

endmodule : gdft_top

// ### sim/gdft_ctrl_model.sv
`timescale 1ns/10ps
module gdft_ctrl_model
  import gdft_pkg::*;
(
  // Clock
  input wire logic i_core_clk,
  // Bench requests
  input wire logic [1:0] i_req,
  input wire logic i_rearm,
  input wire logic [3:0] i_gap,
  // Device status
  input wire logic [1:0] i_status_n,
  // Commands to device
  output logic [1:0] o_cmd
);
  // ----------------------------------------
  // Command drive
  // ----------------------------------------
  logic [1:0][3:0] gap_q;
  logic [1:0] req_s;
  logic rearm_s;
  logic [3:0] gap_s;

  initial begin
    o_cmd = '0;
    gap_q = '0;
    req_s = '0;
    rearm_s = 1'b0;
    gap_s = '0;
  end

  // Requests taken at the rising edge, clear of the falling-edge drive
  always @(posedge i_core_clk) begin
    req_s <= i_req;
    rearm_s <= i_rearm;
    gap_s <= i_gap;
  end

  always @(negedge i_core_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (!rearm_s) begin
        o_cmd[c] <= req_s[c];
      end else if (!i_status_n[c]) begin
        o_cmd[c] <= 1'b0;
        gap_q[c] <= '0;
      end else if (gap_q[c] < gap_s) begin
        gap_q[c] <= gap_q[c] + 4'h1;
      end else begin
        o_cmd[c] <= req_s[c];
      end
    end
  end
endmodule : gdft_ctrl_model

// ### sim/gdft_top_test.sv
`timescale 1ns/10ps
module gdft_top_test;
  import gdft_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int BLK = 20;
  localparam int DLK_P = 64;
  localparam int TPM_P = 80;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [1:0] req = '0, sht = '0, uv = '0, cmd, gate, st_n;
  logic rearm = 1'b0, puv = 1'b0, comm = 1'b0, selft = 1'b0;
  logic [3:0] gap = 4'h3, pres = 4'hf, ntc = 4'hf;
  logic [MEAS_W-1:0] dc = '0;
  logic [3:0][MEAS_W-1:0] temp = '0;
  logic dc_link_pwm_out, temperature_pwm_out, fled, pled;
  int err_total = 0, total_checks = 0, n, m, hi_d, hi_t;
  logic [11:0] rows [5] = '{12'h3bd, 12'hbbc, 12'h7fe, 12'hffc, 12'h1dc};

  always #50 i_core_clk = ~i_core_clk;

  gdft_ctrl_model i_gdft_ctrl_model (.i_core_clk(i_core_clk), .i_req(req),
    .i_rearm(rearm), .i_gap(gap), .i_status_n(st_n), .o_cmd(cmd));

  gdft_top #(.BLOCK_CYCLES(BLK), .DLK_PERIOD(DLK_P), .TPM_PERIOD(TPM_P),
    .DLK_FILT(2), .TPM_FILT(2), .DLK_DLY(4), .TPM_DLY(4)) i_gdft_top (
    .i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_high_side_command_in(cmd[0]), .i_low_side_command_in(cmd[1]),
    .i_high_side_short_det(sht[0]), .i_low_side_short_det(sht[1]),
    .i_high_side_undervolt(uv[0]), .i_low_side_undervolt(uv[1]),
    .i_primary_undervolt(puv), .i_dc_link_meas(dc), .i_temp_meas(temp),
    .i_driver_present(pres), .i_ntc_present(ntc), .i_comm_error(comm),
    .i_self_test_error(selft), .o_high_side_gate_on(gate[0]),
    .o_low_side_gate_on(gate[1]),
    .o_high_side_fault_status_out_n(st_n[0]),
    .o_low_side_fault_status_out_n(st_n[1]), .o_dc_link_pwm_out(dc_link_pwm_out),
    .o_temperature_pwm_out(temperature_pwm_out), .o_fault_led(fled), .o_power_led(pled));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(negedge i_core_clk);
  endtask : cyc

  task automatic pwm_count();
    hi_d = 0;
    hi_t = 0;
    for (int k = 0; k < TPM_P; k++) begin
      if (k < DLK_P && dc_link_pwm_out === 1'b1) hi_d++;
      if (temperature_pwm_out === 1'b1) hi_t++;
      cyc(1);
    end
  endtask : pwm_count

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge i_core_clk);
    err_total++;
    give_verdict();
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    cyc(2);
    check(16'({gate, st_n, dc_link_pwm_out, temperature_pwm_out, fled, pled}), 16'h31);
    i_srst = 1'b0;
    foreach (rows[r]) begin
      {comm, selft, ntc, pres} = rows[r][11:2];
      cyc(4);
      repeat (8) begin
        cyc(10);
        check(16'({dc_link_pwm_out, temperature_pwm_out}), 16'(rows[r][1:0]));
      end
    end
    {comm, selft, ntc, pres} = 10'h0ff;
    dc = 8'h80;
    temp[0] = 8'h0a;
    temp[1] = 8'hc8;
    temp[2] = 8'h32;
    temp[3] = 8'hff;
    pres = 4'h7;
    cyc(200);
    pwm_count();
    check(16'(hi_d), 16'(128 * DLK_P / 256));
    check(16'(hi_t), 16'(200 * TPM_P / 256));
    dc = 8'hff;
    cyc(1);
    dc = 8'h40;
    cyc(200);
    pwm_count();
    check(16'(hi_d), 16'(64 * DLK_P / 256));
    req[0] = 1'b1;
    cyc(2);
    check(16'(gate[0]), 16'h1);
    n = 0;
    sht[0] = 1'b1;
    cyc(1);
    sht[0] = 1'b0;
    while (st_n[0] === 1'b1 && n < 40) begin
      if (gate[0] === 1'b0) n++;
      cyc(1);
    end
    check(16'(n), 16'h5);
    m = 0;
    hi_d = 0;
    while (st_n[0] === 1'b0 && m < 100) begin
      m++;
      if (m == 5) req[0] = 1'b0;
      if (m == 7) req[0] = 1'b1;
      if (gate[0] !== 1'b0) hi_d = 1;
      cyc(1);
    end
    check(16'(m), 16'(BLK));
    check(16'(hi_d), 16'h0);
    check(16'(fled), 16'h1);
    cyc(4);
    check(16'(gate[0]), 16'h0);
    req[0] = 1'b0;
    cyc(2);
    req[0] = 1'b1;
    cyc(2);
    check(16'({gate[0], fled}), 16'h2);
    rearm = 1'b1;
    req = 2'b11;
    cyc(6);
    check(16'(gate), 16'h3);
    puv = 1'b1;
    cyc(2);
    check(16'({gate, st_n}), 16'h0);
    cyc(10);
    check(16'({gate, st_n}), 16'h0);
    puv = 1'b0;
    cyc(12);
    check(16'(st_n), 16'h0);
    cyc(15);
    check(16'(st_n), 16'h3);
    cyc(8);
    check(16'({gate, fled}), 16'h6);
    uv[1] = 1'b1;
    cyc(1);
    uv[1] = 1'b0;
    cyc(1);
    check(16'({gate[1], st_n, fled}), 16'h3);
    req[0] = 1'b0;
    cyc(2);
    req[0] = 1'b1;
    cyc(2);
    check(16'({gate[0], fled}), 16'h3);
    cyc(40);
    check(16'({gate, fled, pled}), 16'hd);
    // Mid-run reset, commands still held high
    i_srst = 1'b1;
    cyc(2);
    check(16'({gate, st_n, fled, pled}), 16'h0d);
    i_srst = 1'b0;
    cyc(2);
    check(16'(gate), 16'h3);
    give_verdict();
  end
endmodule : gdft_top_test
